/* File: core/ecm_monitor.sv */
// Event counter monitor: cycle counter plus event counters on the core clock.
// Assumes event pulses come from core logic on clk_sys; config bits are ports.
// Operation
// - Cycle counter every cycle or every 64
// - Several 32-bit counters, selectable event each
// - Counters read and written by access port
// - Counting never stalls or alters core
// - Enables, zero resets and overflow flags
// - Overflow interrupt when enabled per counter
// - Cycle counter has its own enable
// - Code 0x00 counts software increment writes
// - 0x01 icache refill, 0x14 icache access
// - 0x04 counts data cache accesses
// - 0x0B counts context identifier writes
// - 0x0D counts immediate branches
// - 0x10 counts mispredicted or unpredicted branches
// - 0x11 counts every core cycle
// - 0x12 counts speculative predictable branches
// - 0x0F counts unaligned loads and stores
// - 0x17 counts level two refills
// - User access only when permitted
`timescale 1ns/1ps
module ecm_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ecm_pkg::ecm_events_t events,
    input wire ecm_pkg::ecm_cfg_s cfg,
    input wire logic [ecm_pkg::NCNT-1:0] cnt_clr,
    input wire logic cyc_clr,
    input wire logic [ecm_pkg::NCNT:0] ovf_clr,
    input wire logic [ecm_pkg::NCNT:0] irq_en,
    input wire logic [ecm_pkg::NCNT-1:0] sw_inc,
    input wire ecm_pkg::ecm_acc_s acc,
    output logic [ecm_pkg::CW-1:0] rdata,
    output logic rvalid,
    output logic acc_denied,
    output logic [ecm_pkg::NCNT:0] ovf_flags,
    output logic irq
);
    import ecm_pkg::*;

    // ------------------------------------------------------------
    // Counter state
    // ------------------------------------------------------------
    logic [CW-1:0] cnt_r [NCNT];
    logic [CW-1:0] cyc_r;
    logic [DIV_W-1:0] div_r;
    logic [NCNT:0] ovf_r;
    logic [CW-1:0] rdata_r;
    logic rvalid_r;
    logic denied_r;
    logic irq_r;

    function automatic logic [CW-1:0] inc1(input logic [CW-1:0] v);
        inc1 = v + CW'(1);
    endfunction

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    wire acc_ok = !acc.user || cfg.user_ok;
    wire acc_rd = (acc.op == ACC_RD) && acc_ok;
    wire acc_wr = (acc.op == ACC_WR) && acc_ok;
    wire acc_bad = (acc.op != 2'h0) && !acc_ok;
    wire wr_cyc = acc_wr && (acc.sel == SEL_CYC);
    wire div_tick = !cfg.cyc_div || (div_r == DIV_LAST);
    wire cyc_step = cfg.cyc_en && div_tick;
    wire cyc_wrap = cyc_step && (cyc_r == CNT_MAX);

    logic [NCNT-1:0] step;
    logic [NCNT-1:0] wrap;
    logic [NCNT-1:0] wr_sel;
    logic [CW-1:0] rd_mux;

    // Event selection; code 0x00 follows only the increment writes
    always_comb begin
        for (int i = 0; i < NCNT; i++) begin
            logic [EVW-1:0] code;
            code = cfg.sel[i*EVW +: EVW];
            if (code == EV_SWINC) begin
                step[i] = cfg.en[i] && sw_inc[i];
            end else if (code == EV_CYCLE) begin
                step[i] = cfg.en[i];
            end else if (code <= EV_LAST) begin
                step[i] = cfg.en[i] && events[code[4:0]];
            end else begin
                step[i] = 1'b0;
            end
            wrap[i] = step[i] && (cnt_r[i] == CNT_MAX);
            wr_sel[i] = acc_wr && (acc.sel == 3'(i));
        end
    end

    always_comb begin
        rd_mux = CNT_ZERO;
        if (acc.sel == SEL_CYC) begin
            rd_mux = cyc_r;
        end else if (acc.sel < 3'(NCNT)) begin
            rd_mux = cnt_r[acc.sel[1:0]];
        end
    end

    // ------------------------------------------------------------
    // Counters; clear beats write beats count
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < NCNT; i++) begin
                cnt_r[i] <= CNT_ZERO;
            end
        end else begin
            for (int i = 0; i < NCNT; i++) begin
                if (cnt_clr[i]) begin
                    cnt_r[i] <= CNT_ZERO;
                end else if (wr_sel[i]) begin
                    cnt_r[i] <= acc.wdata;
                end else if (step[i]) begin
                    cnt_r[i] <= inc1(cnt_r[i]);
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cyc_r <= CNT_ZERO;
            div_r <= '0;
        end else begin
            if (cyc_clr) begin
                cyc_r <= CNT_ZERO;
                div_r <= '0;
            end else if (wr_cyc) begin
                cyc_r <= acc.wdata;
            end else if (cyc_step) begin
                cyc_r <= inc1(cyc_r);
            end
            if (cfg.cyc_en && !cyc_clr) begin
                div_r <= div_r + DIV_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Overflow flags, interrupt and read port
    // ------------------------------------------------------------
    wire [NCNT:0] ovf_set = {cyc_wrap, wrap};
    wire [NCNT:0] ovf_nxt = ovf_set | (ovf_r & ~ovf_clr);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ovf_r <= '0;
            irq_r <= 1'b0;
            rdata_r <= CNT_ZERO;
            rvalid_r <= 1'b0;
            denied_r <= 1'b0;
        end else begin
            ovf_r <= ovf_nxt;
            irq_r <= |(ovf_nxt & irq_en);
            rvalid_r <= acc_rd;
            denied_r <= acc_bad;
            if (acc_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
    assign acc_denied = denied_r;
    assign ovf_flags = ovf_r;
    assign irq = irq_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    cyc_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.cyc_en && !cfg.cyc_div && !cyc_clr && !wr_cyc
        |=> cyc_r == $past(cyc_r) + 32'h1)
        else $error("cycle counter did not step");
    cyc_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfg.cyc_en && !cyc_clr && !wr_cyc |=> $stable(cyc_r))
        else $error("cycle counter moved while disabled");
    ovf_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovf_r[0] && !ovf_clr[0] |=> ovf_r[0])
        else $error("overflow flag lost");
    wrap_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrap[0] && !cnt_clr[0] && !wr_sel[0]
        |=> cnt_r[0] == CNT_ZERO && ovf_r[0])
        else $error("wrap did not set flag");
    irq_raise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ovf_r & irq_en & ~ovf_clr) != '0 && $stable(irq_en) |=> irq)
        else $error("interrupt missing");
    clr_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cnt_clr[0] |=> cnt_r[0] == CNT_ZERO)
        else $error("counter not cleared");
    user_deny_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acc.op == ACC_RD && acc.user && !cfg.user_ok |=> !rvalid && acc_denied)
        else $error("user access not denied");
    read_back_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acc_rd |=> rvalid && rdata == $past(rd_mux))
        else $error("read data wrong");
    swinc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.sel[EVW-1:0] == EV_SWINC && !sw_inc[0] && !cnt_clr[0]
        && !wr_sel[0] |=> $stable(cnt_r[0]))
        else $error("software increment counter moved");

    // ------------------------------------------------------------
    // Cycle counter checks
    // ------------------------------------------------------------
    cyc_div_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.cyc_en && cfg.cyc_div && div_r != DIV_LAST && !cyc_clr
        && !wr_cyc |=> $stable(cyc_r))
        else $error("divided cycle counter stepped early");

    cyc_div_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.cyc_en && cfg.cyc_div && div_r == DIV_LAST && !cyc_clr
        && !wr_cyc |=> cyc_r == $past(cyc_r) + 32'h1)
        else $error("divided cycle counter did not step");

    cyc_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cyc_clr |=> cyc_r == CNT_ZERO && div_r == '0)
        else $error("cycle counter not cleared");

    cyc_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cyc_wrap && !cyc_clr && !wr_cyc
        |=> cyc_r == CNT_ZERO && ovf_r[NCNT])
        else $error("cycle counter wrap did not set flag");

    cyc_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_cyc && !cyc_clr |=> cyc_r == $past(acc.wdata))
        else $error("cycle counter write lost");

    // ------------------------------------------------------------
    // Event counter checks
    // ------------------------------------------------------------
    cnt_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        step[0] && !cnt_clr[0] && !wr_sel[0]
        |=> cnt_r[0] == $past(cnt_r[0]) + 32'h1)
        else $error("event counter did not step");

    cnt_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfg.en[0] && !cnt_clr[0] && !wr_sel[0] |=> $stable(cnt_r[0]))
        else $error("disabled event counter moved");

    cnt_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_sel[0] && !cnt_clr[0] |=> cnt_r[0] == $past(acc.wdata))
        else $error("event counter write lost");

    cnt_last_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cnt_clr[NCNT-1] |=> cnt_r[NCNT-1] == CNT_ZERO)
        else $error("last counter not cleared");

    every_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.en[0] && cfg.sel[EVW-1:0] == EV_CYCLE && !cnt_clr[0]
        && !wr_sel[0] |=> cnt_r[0] == $past(cnt_r[0]) + 32'h1)
        else $error("cycle event did not count");

    swinc_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.en[0] && cfg.sel[EVW-1:0] == EV_SWINC && sw_inc[0]
        && !cnt_clr[0] && !wr_sel[0]
        |=> cnt_r[0] == $past(cnt_r[0]) + 32'h1)
        else $error("software increment not counted");

    ev_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.en[0] && cfg.sel[EVW-1:0] != EV_SWINC
        && cfg.sel[EVW-1:0] != EV_CYCLE && cfg.sel[EVW-1:0] <= EV_LAST
        && events[cfg.sel[4:0]] && !cnt_clr[0] && !wr_sel[0]
        |=> cnt_r[0] == $past(cnt_r[0]) + 32'h1)
        else $error("selected event not counted");

    ev_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.sel[EVW-1:0] != EV_SWINC && cfg.sel[EVW-1:0] != EV_CYCLE
        && cfg.sel[EVW-1:0] <= EV_LAST && !events[cfg.sel[4:0]]
        && !cnt_clr[0] && !wr_sel[0] |=> $stable(cnt_r[0]))
        else $error("counter moved without its event");

    reserved_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg.sel[EVW-1:0] > EV_LAST && !cnt_clr[0] && !wr_sel[0]
        |=> $stable(cnt_r[0]))
        else $error("reserved code counted");

    // ------------------------------------------------------------
    // Flag, interrupt and access checks
    // ------------------------------------------------------------
    ovf_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovf_clr[0] && !wrap[0] |=> !ovf_r[0])
        else $error("overflow flag not cleared");

    ovf_set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrap[0] && ovf_clr[0] |=> ovf_r[0])
        else $error("clear beat overflow set");

    irq_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ovf_nxt & irq_en) == '0 |=> !irq)
        else $error("interrupt without enabled flag");

    user_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acc.op == ACC_WR && acc.user && !cfg.user_ok && acc.sel == '0
        && !cnt_clr[0] && !cfg.en[0] |=> $stable(cnt_r[0]) && acc_denied)
        else $error("user write not refused");

    user_ok_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acc.op == ACC_RD && acc.user && cfg.user_ok
        |=> rvalid && !acc_denied)
        else $error("permitted user read refused");

    idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acc.op == '0 |=> !rvalid && !acc_denied)
        else $error("answer without access");

    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !acc_rd |=> $stable(rdata))
        else $error("read data changed without read");
endmodule

/* File: core/ecm_pkg.sv */
// Package for the event counter monitor: event codes, widths, carriers.
// Assumes a single core clock domain; no register bus.
package ecm_pkg;
    localparam int NCNT = 4;
    localparam int CW = 32;
    localparam int EVW = 8;
    localparam int NEV = 32;
    localparam int DIV_W = 6;
    localparam logic [DIV_W-1:0] DIV_LAST = 6'h3F;
    localparam logic [CW-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CW-1:0] CNT_MAX = 32'hFFFF_FFFF;
    localparam logic [EVW-1:0] EV_SWINC = 8'h00;
    localparam logic [EVW-1:0] EV_CYCLE = 8'h11;
    localparam logic [EVW-1:0] EV_LAST = 8'h1D;
    localparam logic [1:0] ACC_WR = 2'h1;
    localparam logic [1:0] ACC_RD = 2'h2;
    localparam logic [2:0] SEL_CYC = 3'h4;

    // Event code sets the bit with the same index
    typedef logic [NEV-1:0] ecm_events_t;

    typedef struct packed {
        logic [1:0] op;
        logic user;
        logic [2:0] sel;
        logic [CW-1:0] wdata;
    } ecm_acc_s;

    typedef struct packed {
        logic [NCNT-1:0] en;
        logic cyc_en;
        logic cyc_div;
        logic user_ok;
        logic [NCNT*EVW-1:0] sel;
    } ecm_cfg_s;
endpackage

/* File: test/ecm_monitor_tb.sv */
// Self-checking bench for the event counter monitor.
// Assumes ecm_pkg and ecm_monitor are compiled first; single clock.
`timescale 1ns/1ps
module ecm_monitor_tb;
    import ecm_pkg::*;
    typedef struct packed {
        logic [7:0] code;
        logic [31:0] exp;
    } ecm_row_s;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    ecm_events_t events = '0;
    ecm_cfg_s cfg = '0;
    logic [NCNT-1:0] cnt_clr = '0;
    logic cyc_clr = 1'b0;
    logic [NCNT:0] ovf_clr = '0;
    logic [NCNT:0] irq_en = '0;
    logic [NCNT-1:0] sw_inc = '0;
    ecm_acc_s acc = '0;
    logic [CW-1:0] rdata;
    logic rvalid;
    logic acc_denied;
    logic [NCNT:0] ovf_flags;
    logic irq;
    int num_errors = 0;
    int comparisons = 0;
    ecm_row_s rows [13] = '{'{8'h00, 32'h3}, '{8'h01, 32'h3}, '{8'h14, 32'h3},
        '{8'h04, 32'h3}, '{8'h0B, 32'h3}, '{8'h0D, 32'h3}, '{8'h10, 32'h3},
        '{8'h12, 32'h3}, '{8'h0F, 32'h3}, '{8'h17, 32'h3}, '{8'h11, 32'h5},
        '{8'h1D, 32'h3}, '{8'h1E, 32'h0}};

    ecm_monitor uut (.clk_sys(clk_sys), .rst_n(rst_n), .events(events),
        .cfg(cfg), .cnt_clr(cnt_clr), .cyc_clr(cyc_clr), .ovf_clr(ovf_clr),
        .irq_en(irq_en), .sw_inc(sw_inc), .acc(acc), .rdata(rdata),
        .rvalid(rvalid), .acc_denied(acc_denied), .ovf_flags(ovf_flags),
        .irq(irq));

    always #5 clk_sys = ~clk_sys;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic access(input logic [1:0] op, input logic u,
                          input logic [2:0] s, input logic [31:0] d);
        acc = '{op, u, s, d};
        tick(1);
        acc = '0;
    endtask

    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        #200us;
        num_errors++;
        stop_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        tick(5);
        rst_n = 1'b1;
        chk("flags", 32'h0, {27'h0, ovf_flags});
        $display("test reset done");
        // Divider: first count after 64 enabled cycles
        cfg.cyc_en = 1'b1;
        cfg.cyc_div = 1'b1;
        tick(63);
        cfg.cyc_en = 1'b0;
        access(ACC_RD, 1'b0, SEL_CYC, 32'h0);
        chk("cyc63", 32'h0, rdata);
        cfg.cyc_en = 1'b1;
        tick(1);
        cfg.cyc_en = 1'b0;
        access(ACC_RD, 1'b0, SEL_CYC, 32'h0);
        chk("cyc64", 32'h1, rdata);
        cfg.cyc_div = 1'b0;
        cyc_clr = 1'b1;
        tick(1);
        cyc_clr = 1'b0;
        cfg.cyc_en = 1'b1;
        tick(5);
        cfg.cyc_en = 1'b0;
        access(ACC_RD, 1'b0, SEL_CYC, 32'h0);
        chk("cyc5", 32'h5, rdata);
        $display("test cycle done");
        foreach (rows[i]) begin
            cfg.sel[7:0] = rows[i].code;
            cnt_clr[0] = 1'b1;
            tick(1);
            cnt_clr[0] = 1'b0;
            cfg.en[0] = 1'b1;
            events = '1;
            sw_inc[0] = (rows[i].code == EV_SWINC);
            tick(3);
            sw_inc[0] = 1'b0;
            events = ~(32'h1 << rows[i].code);
            tick(2);
            cfg.en[0] = 1'b0;
            events = '0;
            access(ACC_RD, 1'b0, 3'h0, 32'h0);
            chk("rvalid", 32'h1, {31'h0, rvalid});
            chk("count", rows[i].exp, rdata);
        end
        $display("test events done");
        // Wrap, sticky flag, interrupt mask and clear
        cfg.sel[15:8] = EV_CYCLE;
        irq_en = 5'h02;
        access(ACC_WR, 1'b0, 3'h1, CNT_MAX);
        tick(1);
        cfg.en[1] = 1'b1;
        tick(1);
        cfg.en[1] = 1'b0;
        tick(3);
        chk("flags", 32'h2, {27'h0, ovf_flags});
        chk("irq", 32'h1, {31'h0, irq});
        access(ACC_RD, 1'b0, 3'h1, 32'h0);
        chk("wrap", CNT_ZERO, rdata);
        irq_en = 5'h0;
        tick(2);
        chk("irq_off", 32'h0, {31'h0, irq});
        ovf_clr = 5'h02;
        tick(1);
        ovf_clr = 5'h0;
        tick(2);
        chk("flags", 32'h0, {27'h0, ovf_flags});
        // Cycle counter wrap sets its own flag
        access(ACC_WR, 1'b0, SEL_CYC, CNT_MAX);
        cfg.cyc_en = 1'b1;
        tick(1);
        cfg.cyc_en = 1'b0;
        chk("cyc_flag", 32'h10, {27'h0, ovf_flags});
        ovf_clr = 5'h10;
        tick(1);
        ovf_clr = 5'h0;
        chk("cyc_flag_clr", 32'h0, {27'h0, ovf_flags});
        $display("test overflow done");
        // User access refused unless permitted
        access(ACC_RD, 1'b1, SEL_CYC, 32'h0);
        chk("denied", 32'h1, {31'h0, acc_denied});
        chk("rvalid", 32'h0, {31'h0, rvalid});
        tick(1);
        access(ACC_WR, 1'b1, 3'h1, 32'h55);
        tick(1);
        access(ACC_RD, 1'b0, 3'h1, 32'h0);
        chk("nowrite", 32'h0, rdata);
        cfg.user_ok = 1'b1;
        tick(1);
        access(ACC_RD, 1'b1, 3'h1, 32'h0);
        chk("user_rd", 32'h1, {31'h0, rvalid});
        $display("test user done");
        stop_test();
    end
endmodule
